/* File: logic/pmic_status_flag_irq.sv */
// Sticky event flags, unmask registers and interrupt pin of the PMIC.
// Assumes the bus slave presents one-cycle register requests on core_clk.
`timescale 1ns/1ps
module pmic_status_flag_irq (
  input  wire logic                      core_clk,
  input  wire logic                      reset_n,
  input  wire flag_irq_pkg::reg_req_type reg_req,
  output logic                     [7:0] reg_rdata,
  output logic                           reg_rvalid,
  input  wire flag_irq_pkg::measure_type measure,
  input  wire flag_irq_pkg::limits_type  limits,
  input  wire logic                      cal_complete,
  input  wire logic                      count_over_limit,
  input  wire logic                      bus_error,
  input  wire logic                      fuse_crc_error,
  input  wire logic                      fuse_loaded,
  input  wire logic                [2:0] output_in_regulation,
  output logic                           irq_n,
  output logic                           irq_oe_n
);
  logic [1:0] rst_sync_q;
  logic       rst_n;
  logic [7:0] general_unmask_q;
  logic [7:0] regulation_unmask_q;
  logic [7:0] general_flags_q;
  logic [7:0] regulation_flags_q;
  logic [7:0] general_set;
  logic [7:0] regulation_set;
  logic [2:0] entered;
  logic [2:0] dropped;
  logic [11:0] monitored_supply;
  logic       periodic_ok;
  logic       summary_level;
  logic       fuse_seen_q;
  logic       irq_q;
  logic [7:0] rdata_q;
  logic       rvalid_q;
  logic       wr_general;
  logic       wr_regulation;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  assign wr_general    = reg_req.write &&
                         reg_req.addr == flag_irq_pkg::general_flags_addr;
  assign wr_regulation = reg_req.write &&
                         reg_req.addr == flag_irq_pkg::regulation_flags_addr;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      general_unmask_q    <= flag_irq_pkg::general_unmask_reset;
      regulation_unmask_q <= flag_irq_pkg::regulation_unmask_reset;
    end else if (reg_req.write) begin
      if (reg_req.addr == flag_irq_pkg::general_unmask_addr) begin
        general_unmask_q <= reg_req.wdata;
      end
      if (reg_req.addr == flag_irq_pkg::regulation_unmask_addr) begin
        regulation_unmask_q <= reg_req.wdata &
                               flag_irq_pkg::regulation_valid;
      end
    end
  end

  regulation_edge_detect u_edges (
    .clk     (core_clk),
    .rst_n   (rst_n),
    .in_reg  (output_in_regulation),
    .entered (entered),
    .dropped (dropped)
  );

  always_comb begin
    regulation_set = 8'h00;
    regulation_set[flag_irq_pkg::dropped_base +: flag_irq_pkg::outputs] =
      dropped;
    regulation_set[flag_irq_pkg::regulating_base +: flag_irq_pkg::outputs] =
      entered;
  end

  flag_w1c_bank u_regulation (
    .clk        (core_clk),
    .rst_n      (rst_n),
    .set_pulse  (regulation_set),
    .clear_en   (wr_regulation),
    .clear_bits (reg_req.wdata),
    .valid_bits (flag_irq_pkg::regulation_valid),
    .flags_q    (regulation_flags_q)
  );

  // Supply source mux, then limits checked only on periodic samples
  assign monitored_supply = limits.supply_source_select ?
                            measure.supply_a : measure.supply_b;
  assign periodic_ok = measure.measure_done &&
                       limits.measure_interval != 8'h00;
  assign summary_level = |(regulation_flags_q & regulation_unmask_q);

  // Fuse contents are read at every reset release; catch that once
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fuse_seen_q <= 1'b0;
    end else begin
      fuse_seen_q <= 1'b1;
    end
  end

  always_comb begin
    general_set = 8'h00;
    general_set[flag_irq_pkg::supply_low_bit] = periodic_ok &&
      monitored_supply < limits.supply_low_limit;
    general_set[flag_irq_pkg::cal_done_bit]   = cal_complete;
    general_set[flag_irq_pkg::count_over_bit] = count_over_limit;
    general_set[flag_irq_pkg::summary_bit]    = summary_level;
    general_set[flag_irq_pkg::temp_high_bit]  = periodic_ok &&
      measure.temperature > limits.temp_high_limit;
    general_set[flag_irq_pkg::bus_error_bit]  = bus_error;
    general_set[flag_irq_pkg::fuse_crc_bit]   = fuse_crc_error;
    general_set[flag_irq_pkg::fuse_load_bit]  = fuse_loaded ||
      !fuse_seen_q;
  end

  flag_w1c_bank u_general (
    .clk        (core_clk),
    .rst_n      (rst_n),
    .set_pulse  (general_set),
    .clear_en   (wr_general),
    .clear_bits (reg_req.wdata),
    .valid_bits (8'hff),
    .flags_q    (general_flags_q)
  );

  // Open-drain pin, registered to keep glitches off the host line
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(general_flags_q & general_unmask_q);
    end
  end
  assign irq_n    = 1'b0;
  assign irq_oe_n = ~irq_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_req.read;
      if (reg_req.read) begin
        unique case (reg_req.addr)
          flag_irq_pkg::general_flags_addr:    rdata_q <= general_flags_q;
          flag_irq_pkg::regulation_flags_addr: rdata_q <= regulation_flags_q;
          flag_irq_pkg::general_unmask_addr:   rdata_q <= general_unmask_q;
          flag_irq_pkg::regulation_unmask_addr:
            rdata_q <= regulation_unmask_q;
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end
  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;
endmodule // pmic_status_flag_irq

/* File: logic/flag_irq_pkg.sv */
// Constants, field layout and carrier types of the event-flag block.
// Assumes a register port decoded by the serial-bus slave outside it.
// Operation
// - Set supply-low flag when selected supply is below supply_low_limit.
// - Supply and temperature checks run only on periodic, non-zero interval.
// - General flags 7 to 1 reset masked; unmask bit lets each through.
// - Flags stay set until a 1 is written; writing 0 changes nothing.
// - Set calibration-done flag when a charge-counter calibration ends.
// - Set over-limit flag when any charge counter exceeds charge_count_limit.
// - Set summary flag when any unmasked regulation flag is asserted.
// - Set over-temperature flag when temperature exceeds temp_high_limit.
// - Set bus-error flag on a serial control bus error.
// - Set fuse-checksum flag when the fuse checksum check fails.
// - Set fuse-load flag every time fuses are read, including after reset.
// - Fuse-load flag resets unmasked so reset release raises the interrupt.
// - Regulation bits 5 to 3 set on leaving regulation; 7:6 reserved.
// - Regulation bits 2 to 0 set on entering regulation.
package flag_irq_pkg;
  localparam logic [7:0] general_flags_addr    = 8'h00;
  localparam logic [7:0] regulation_flags_addr = 8'h01;
  localparam logic [7:0] general_unmask_addr   = 8'h02;
  localparam logic [7:0] regulation_unmask_addr = 8'h03;

  localparam int supply_low_bit  = 7;
  localparam int cal_done_bit    = 6;
  localparam int count_over_bit  = 5;
  localparam int summary_bit     = 4;
  localparam int temp_high_bit   = 3;
  localparam int bus_error_bit   = 2;
  localparam int fuse_crc_bit    = 1;
  localparam int fuse_load_bit   = 0;
  localparam int outputs         = 3;
  localparam int dropped_base    = 3;
  localparam int regulating_base = 0;

  localparam logic [7:0] flags_reset          = 8'h00;
  localparam logic [7:0] general_unmask_reset = 8'h01;
  localparam logic [7:0] regulation_unmask_reset = 8'h00;
  localparam logic [7:0] regulation_valid     = 8'h3f;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic        measure_done;
    logic [11:0] supply_a;
    logic [11:0] supply_b;
    logic [11:0] temperature;
  } measure_type;

  typedef struct packed {
    logic        supply_source_select;
    logic [11:0] supply_low_limit;
    logic [11:0] temp_high_limit;
    logic [7:0]  measure_interval;
  } limits_type;
endpackage

/* File: logic/flag_w1c_bank.sv */
// Eight sticky flags with write-one-to-clear and set priority.
// Assumes set pulses synchronous to clk.
`timescale 1ns/1ps
module flag_w1c_bank (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] set_pulse,
  input  wire logic       clear_en,
  input  wire logic [7:0] clear_bits,
  input  wire logic [7:0] valid_bits,
  output logic      [7:0] flags_q
);
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_flag
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          flags_q[i] <= 1'b0;
        end else if (!valid_bits[i]) begin
          flags_q[i] <= 1'b0;
        end else if (set_pulse[i]) begin
          flags_q[i] <= 1'b1;
        end else if (clear_en && clear_bits[i]) begin
          flags_q[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule // flag_w1c_bank

/* File: logic/regulation_edge_detect.sv */
// Turns per-output in-regulation levels into entry and exit pulses.
// Assumes levels already synchronous; first sample after reset is a baseline.
`timescale 1ns/1ps
module regulation_edge_detect (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] in_reg,
  output logic      [2:0] entered,
  output logic      [2:0] dropped
);
  logic [2:0] prev_q;
  logic       primed_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q   <= 3'h0;
      primed_q <= 1'b0;
    end else begin
      prev_q   <= in_reg;
      primed_q <= 1'b1;
    end
  end

  // Small target steps never leave regulation, so no entry pulse either
  assign entered = primed_q ? (in_reg & ~prev_q) : 3'h0;
  assign dropped = primed_q ? (~in_reg & prev_q) : 3'h0;
endmodule // regulation_edge_detect

/* File: dv/pmic_status_flag_irq_chk.sv */
// Port-level checks of the event-flag block.
// Assumes a bind onto pmic_status_flag_irq; one clock domain.
`timescale 1ns/1ps
module flag_irq_chk (
  input wire logic                      core_clk,
  input wire logic                      reset_n,
  input wire flag_irq_pkg::reg_req_type reg_req,
  input wire logic                [7:0] reg_rdata,
  input wire logic                      reg_rvalid,
  input wire logic                      fuse_loaded,
  input wire logic                      irq_oe_n
);
  logic um0_q;
  wire  rd_w = reg_req.read;
  wire  um_w = reg_req.write &&
               reg_req.addr == flag_irq_pkg::general_unmask_addr;
  // Shadow of the fuse-load unmask bit, so the pin check knows its gate
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) um0_q <= 1'b1;
    else if (um_w) um0_q <= reg_req.wdata[0];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_fuse;
    fuse_loaded && um0_q && !um_w;
  endsequence
  sequence s_boot;
    irq_oe_n [*3] ##[1:3] !irq_oe_n;
  endsequence
  a_read_answer: assert property (rd_w |=> reg_rvalid)
    else $error("read without answer");
  a_rvalid_pulse: assert property (!rd_w |=> !reg_rvalid)
    else $error("answer without read");
  a_unmapped_zero: assert property
    (rd_w && reg_req.addr > 8'h03 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reserved_zero: assert property
    (rd_w && reg_req.addr[7:1] == 7'h00 && reg_req.addr[0]
     |=> reg_rdata[7:6] == 2'b00)
    else $error("reserved bits not zero");
  a_rdata_held: assert property (!rd_w |=> $stable(reg_rdata))
    else $error("read data moved");
  a_fuse_irq: assert property (s_fuse |-> ##2 !irq_oe_n)
    else $error("fuse load gave no interrupt");
  a_mask_quiet: assert property
    (um_w && reg_req.wdata == 8'h00 |-> ##2 irq_oe_n)
    else $error("interrupt while all masked");
  a_boot_irq: assert property ($rose(reset_n) |-> s_boot)
    else $error("no interrupt after reset");
endmodule // flag_irq_chk
bind pmic_status_flag_irq flag_irq_chk chk (.core_clk(core_clk),
  .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .fuse_loaded(fuse_loaded), .irq_oe_n(irq_oe_n));

/* File: dv/host_model.sv */
// Host side of the register port: reads, writes, interrupt service.
// Assumes strobes sampled on the rising edge, answer one cycle later.
`timescale 1ns/1ps
module host_model (
  input  wire logic                 clk,
  input  wire logic           [7:0] rdata,
  input  wire logic                 rvalid,
  output flag_irq_pkg::reg_req_type req
);
  initial req = {1'b0, 1'b0, 8'h5a, 8'ha5};
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    req = {1'b1, 1'b0, a, d};
    @(posedge clk) #1;
    req = {1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge clk) #1;
    req = {1'b0, 1'b1, a, 8'h00};
    @(posedge clk) #1;
    d = rdata;
    v = rvalid;
    req = {1'b0, 1'b0, ~a, 8'hff};
  endtask
  // One status read suffices unless the summary bit points further
  task automatic isr();
    logic [7:0] g;
    logic [7:0] r;
    logic       v;
    rd(8'h00, g, v);
    if (g[4]) begin
      rd(8'h01, r, v);
      wr(8'h01, r);
    end
    wr(8'h00, g);
  endtask
endmodule // host_model

/* File: dv/pmic_status_flag_irq_tb.sv */
// Self-checking bench of the event-flag block.
// Assumes host_model and the bound checker compiled alongside.
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin \
  n_fail++; $display("CHECK FAILED %s expected %h seen %h", n, e, a); \
  end end
module pmic_status_flag_irq_tb;
  logic                      core_clk = 1'b0;
  logic                      reset_n = 1'b0;
  logic                [7:0] ev_v = 8'h00;
  logic                [2:0] in_reg = 3'h0;
  logic                [7:0] rdata;
  logic                      rvalid;
  logic                      irq_oe_n;
  logic                      irq_n;
  flag_irq_pkg::reg_req_type req;
  flag_irq_pkg::measure_type meas = {1'b0, 12'hfff, 12'hfff, 12'h000};
  flag_irq_pkg::limits_type  lim = {1'b0, 12'h100, 12'h800, 8'h00};
  int                        n_fail = 0;
  int                        total_checks = 0;
  int                        bits[7] = '{7, 6, 5, 3, 2, 1, 0};
  always #25 core_clk = ~core_clk;
  pmic_status_flag_irq DUT (.core_clk(core_clk), .reset_n(reset_n),
    .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .measure(meas), .limits(lim), .cal_complete(ev_v[6]),
    .count_over_limit(ev_v[5]), .bus_error(ev_v[2]),
    .fuse_crc_error(ev_v[1]), .fuse_loaded(ev_v[0]),
    .output_in_regulation(in_reg), .irq_n(irq_n), .irq_oe_n(irq_oe_n));
  host_model h (.clk(core_clk), .rdata(rdata), .rvalid(rvalid), .req(req));
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    h.rd(a, d, v);
    `CHK("read valid", 1'b1, v)
    `CHK("read data", e, d)
  endtask
  // One-cycle event; bits 7 and 3 come from a periodic sample
  task automatic ev(input int b);
    @(posedge core_clk) #1;
    ev_v = 8'h01 << b;
    meas.measure_done = (b == 7) || (b == 3);
    if (b == 7) meas.supply_b = 12'h000;
    if (b == 3) meas.temperature = 12'hfff;
    @(posedge core_clk) #1;
    ev_v = 8'h00;
    meas = {1'b0, 12'hfff, 12'hfff, 12'h000};
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("irq pin", e, irq_oe_n)
    `CHK("irq level", 1'b0, irq_n)
  endtask
  task automatic results();
    if (n_fail == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #2000000;
    n_fail++;
    results();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    #1 reset_n = 1'b1;
    irq_is(1'b1);
    irq_is(1'b0);
    rc(8'h00, 8'h01);
    rc(8'h02, 8'h01);
    rc(8'h01, 8'h00);
    rc(8'h03, 8'h00);
    rc(8'h09, 8'h00);
    h.wr(8'h00, 8'hfe);
    rc(8'h00, 8'h01);
    h.wr(8'h00, 8'h01);
    irq_is(1'b1);
    ev(7);
    lim.measure_interval = 8'h04;
    lim.supply_source_select = 1'b1;
    ev(7);
    rc(8'h00, 8'h00);
    lim.supply_source_select = 1'b0;
    foreach (bits[i]) begin
      ev(bits[i]);
      irq_is(bits[i] != 0);
      rc(8'h00, 8'h01 << bits[i]);
      h.wr(8'h02, (8'h01 << bits[i]) | 8'h01);
      irq_is(1'b0);
      h.wr(8'h00, 8'h01 << bits[i]);
      irq_is(1'b1);
    end
    h.wr(8'h03, 8'hff);
    rc(8'h03, 8'h3f);
    h.wr(8'h02, 8'h11);
    @(posedge core_clk) #1 in_reg = 3'h7;
    rc(8'h01, 8'h07);
    rc(8'h00, 8'h10);
    irq_is(1'b0);
    @(posedge core_clk) #1 in_reg = 3'h0;
    rc(8'h01, 8'h3f);
    h.isr();
    irq_is(1'b1);
    rc(8'h01, 8'h00);
    // Masked regulation flag must not reach the summary bit
    h.wr(8'h03, 8'h00);
    @(posedge core_clk) #1 in_reg = 3'h1;
    rc(8'h01, 8'h01);
    rc(8'h00, 8'h00);
    fork
      h.wr(8'h00, 8'h01);
      ev(0);
    join
    rc(8'h00, 8'h01);
    h.wr(8'h02, 8'h00);
    irq_is(1'b1);
    results();
  end
endmodule // pmic_status_flag_irq_tb
